// >>> design/hdr_cmp_pkg.sv
package hdr_cmp_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_F1 = 8'h04;
  localparam logic [7:0] OFF_F2_MATCH_LO = 8'h08;
  localparam logic [7:0] OFF_F2_MATCH_HI = 8'h0c;
  localparam logic [7:0] OFF_F2_MASK_LO = 8'h10;
  localparam logic [7:0] OFF_F2_MASK_HI = 8'h14;
  localparam logic [7:0] OFF_NEXT = 8'h18;
  localparam logic [7:0] OFF_UDP = 8'h1c;
  localparam logic [7:0] OFF_FLOW_CTRL = 8'h20;
  localparam logic [7:0] OFF_FLOW_MATCH0 = 8'h30;
  localparam logic [7:0] OFF_FLOW_MASK0 = 8'h40;
  localparam logic [7:0] OFF_STATUS = 8'h50;

  // field positions
  localparam int F1_MATCH_LSB = 0;
  localparam int F1_MASK_LSB = 8;
  localparam int F1_POS_LSB = 16;
  localparam int NEXT_LEN_LSB = 0;
  localparam int NEXT_PTR_LSB = 8;
  localparam int NEXT_FLOWPOS_LSB = 16;
  localparam int UDP_ZERO_BIT = 0;
  localparam int UDP_FIX_BIT = 1;
  localparam int UDP_LEN_LSB = 2;
  localparam int UDP_LOC_LSB = 8;
  localparam int FLOW_EN_BIT = 0;
  localparam int FLOW_SEL_LSB = 1;

  // reset values
  localparam logic [1:0] UDP_LEN_RST = 2'h2;
  localparam logic [2:0] PTR_RST = 3'h0;

  // header constants
  localparam logic [3:0] VER_V4 = 4'h4;
  localparam logic [3:0] VER_V6 = 4'h6;
  localparam int HDR_BYTES = 64;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    MODE_IPV4 = 2'h0,
    MODE_IPV6 = 2'h1,
    MODE_OTHER32 = 2'h2,
    MODE_OTHER128 = 2'h3
  } proto_mode_t;

  typedef enum logic [1:0]
  {
    SEL_SRC = 2'h0,
    SEL_DST = 2'h1,
    SEL_EITHER = 2'h2
  } addr_sel_t;

  // result handed to the following stage
  typedef struct packed
  {
    logic valid;
    logic header_ok;
    logic flow_hit;
    logic [2:0] next_ptr;
    logic [7:0] hdr_len;
    logic sum_zero;
    logic sum_fix;
    logic [7:0] sum_loc;
    logic [1:0] sum_len;
  } stage_result_t;
endpackage

// >>> design/hdr_cmp.sv
`timescale 1ns/1ps

// What this block does
// - two-bit mode picks ipv4, ipv6, other kinds
// - version checked 4 or 6, none otherwise
// - ipv4 needs zero fragment offset and mf
// - first pair compares one masked header byte
// - all-zero mask disables a pair
// - five-bit byte position places first pair
// - second pair 64 bits, seven-bit position
// - header length comes from configuration only
// - three-bit pointer names the next stage
// - five-bit flow position locates flow field
// - zero-sum setting clears udp checksum
// - fixup setting repairs ipv6 udp checksum
// - ipv4 checksum location forwarded downstream
// - two-bit checksum length in bytes
// - ip modes match source or destination address
// - other modes match masked 32/128-bit field
// - address select source, destination or either
// - ipv4 uses only upper 32 flow bits
// - flow enable bit gates the flow hit
module hdr_cmp
  import hdr_cmp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // header window from the preceding stage, byte 0 at bits [7:0]
  input wire logic hdr_valid,
  input wire logic [8*HDR_BYTES-1:0] hdr_bytes,
  // result to the following stage
  output stage_result_t result,
  // axi4-lite write address
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // axi4-lite write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // axi4-lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read address
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // axi4-lite read data
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  // configuration registers
  proto_mode_t protocol_mode_select_reg;
  logic [7:0] first_field_match_reg;
  logic [7:0] first_field_mask_reg;
  logic [4:0] first_field_position_reg;
  logic [63:0] second_field_match_reg;
  logic [63:0] second_field_mask_reg;
  logic [6:0] second_field_position_reg;
  logic [7:0] header_length_bytes_reg;
  logic [2:0] next_stage_pointer_reg;
  logic [4:0] flow_field_position_reg;
  logic udp_sum_zero_enable_reg;
  logic udp_sum_fixup_enable_reg;
  logic [7:0] udp_sum_location_reg;
  logic [1:0] udp_sum_length_reg;
  logic flow_enable_bit_reg;
  addr_sel_t flow_address_select_reg;
  logic [127:0] flow_match_value_reg;
  logic [127:0] flow_match_mask_reg;
  // result register
  stage_result_t result_reg;
  stage_result_t result_next;
  // count of headers checked, visible to software
  logic [15:0] hdr_count_reg;
  logic [15:0] hit_count_reg;

  // bus slave holding registers
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic wr_err;

  // ---------------- write channel ----------------
  // each channel is taken on its own; write happens once both are held
  assign s_awready = !aw_held_reg && !s_bvalid;
  assign s_wready = !w_held_reg && !s_bvalid;
  assign do_write = aw_held_reg && w_held_reg && !s_bvalid;

  // capture address and data independently, release on the write
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_awaddr;
      end
      else if (do_write)
        aw_held_reg <= 1'b0;
      if (s_wvalid && s_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_wdata;
        wstrb_reg <= s_wstrb;
      end
      else if (do_write)
        w_held_reg <= 1'b0;
    end
  end

  // byte-lane merge of write data into a 32-bit old value
  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] new_val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = new_val[8*b +: 8];
    return res;
  endfunction

  // decode errors on write: unmapped or read-only address
  always_comb
  begin
    wr_err = 1'b0;
    if (awaddr_reg[1:0] != 2'h0)
      wr_err = 1'b1;
    else if (awaddr_reg == OFF_STATUS)
      wr_err = 1'b1;
    else if (awaddr_reg > OFF_FLOW_MASK0 + 8'h0c)
      wr_err = 1'b1;
    else if (awaddr_reg > OFF_FLOW_CTRL && awaddr_reg < OFF_FLOW_MATCH0)
      wr_err = 1'b1;
  end

  // configuration register writes, merged by byte strobe
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      protocol_mode_select_reg <= MODE_IPV4;
      first_field_match_reg <= 8'h00;
      first_field_mask_reg <= 8'h00;
      first_field_position_reg <= 5'h00;
      second_field_match_reg <= 64'h0;
      second_field_mask_reg <= 64'h0;
      second_field_position_reg <= 7'h00;
      header_length_bytes_reg <= 8'h00;
      next_stage_pointer_reg <= PTR_RST;
      flow_field_position_reg <= 5'h00;
      udp_sum_zero_enable_reg <= 1'b0;
      udp_sum_fixup_enable_reg <= 1'b0;
      udp_sum_location_reg <= 8'h00;
      udp_sum_length_reg <= UDP_LEN_RST;
      flow_enable_bit_reg <= 1'b0;
      flow_address_select_reg <= SEL_SRC;
      flow_match_value_reg <= 128'h0;
      flow_match_mask_reg <= 128'h0;
    end
    else if (do_write && !wr_err)
    begin
      logic [31:0] m;
      m = 32'h0;
      if (awaddr_reg == OFF_MODE)
      begin
        m = merge({30'h0, protocol_mode_select_reg}, wdata_reg, wstrb_reg);
        protocol_mode_select_reg <= proto_mode_t'(m[1:0]);
      end
      else if (awaddr_reg == OFF_F1)
      begin
        m = merge({11'h0, first_field_position_reg, first_field_mask_reg,
                   first_field_match_reg}, wdata_reg, wstrb_reg);
        first_field_match_reg <= m[F1_MATCH_LSB +: 8];
        first_field_mask_reg <= m[F1_MASK_LSB +: 8];
        first_field_position_reg <= m[F1_POS_LSB +: 5];
      end
      else if (awaddr_reg == OFF_F2_MATCH_LO)
        second_field_match_reg[31:0] <=
          merge(second_field_match_reg[31:0], wdata_reg, wstrb_reg);
      else if (awaddr_reg == OFF_F2_MATCH_HI)
        second_field_match_reg[63:32] <=
          merge(second_field_match_reg[63:32], wdata_reg, wstrb_reg);
      else if (awaddr_reg == OFF_F2_MASK_LO)
        second_field_mask_reg[31:0] <=
          merge(second_field_mask_reg[31:0], wdata_reg, wstrb_reg);
      else if (awaddr_reg == OFF_F2_MASK_HI)
        second_field_mask_reg[63:32] <=
          merge(second_field_mask_reg[63:32], wdata_reg, wstrb_reg);
      else if (awaddr_reg == OFF_NEXT)
      begin
        m = merge({1'b0, second_field_position_reg, 3'h0,
                   flow_field_position_reg, 5'h00,
                   next_stage_pointer_reg, header_length_bytes_reg},
                  wdata_reg, wstrb_reg);
        header_length_bytes_reg <= m[NEXT_LEN_LSB +: 8];
        next_stage_pointer_reg <= m[NEXT_PTR_LSB +: 3];
        flow_field_position_reg <= m[NEXT_FLOWPOS_LSB +: 5];
        second_field_position_reg <= m[30:24];
      end
      else if (awaddr_reg == OFF_UDP)
      begin
        m = merge({16'h0, udp_sum_location_reg, 4'h0, udp_sum_length_reg,
                   udp_sum_fixup_enable_reg, udp_sum_zero_enable_reg},
                  wdata_reg, wstrb_reg);
        udp_sum_zero_enable_reg <= m[UDP_ZERO_BIT];
        udp_sum_fixup_enable_reg <= m[UDP_FIX_BIT];
        udp_sum_length_reg <= m[UDP_LEN_LSB +: 2];
        udp_sum_location_reg <= m[UDP_LOC_LSB +: 8];
      end
      else if (awaddr_reg == OFF_FLOW_CTRL)
      begin
        m = merge({29'h0, flow_address_select_reg, flow_enable_bit_reg},
                  wdata_reg, wstrb_reg);
        flow_enable_bit_reg <= m[FLOW_EN_BIT];
        flow_address_select_reg <= addr_sel_t'(m[FLOW_SEL_LSB +: 2]);
      end
      else if (awaddr_reg >= OFF_FLOW_MATCH0 && awaddr_reg < OFF_FLOW_MASK0)
      begin
        // word 3 at offset +0x0c holds the upper 32 bits
        flow_match_value_reg[32*awaddr_reg[3:2] +: 32] <=
          merge(flow_match_value_reg[32*awaddr_reg[3:2] +: 32],
                wdata_reg, wstrb_reg);
      end
      else
      begin
        flow_match_mask_reg[32*awaddr_reg[3:2] +: 32] <=
          merge(flow_match_mask_reg[32*awaddr_reg[3:2] +: 32],
                wdata_reg, wstrb_reg);
      end
    end
  end

  // write response stands until the master takes it
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_bvalid <= 1'b1;
      s_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_bready)
      s_bvalid <= 1'b0;
  end

  // ---------------- read channel ----------------
  assign s_arready = !s_rvalid;

  // read data registered one cycle after the address is taken
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_rvalid <= 1'b1;
      s_rresp <= RESP_OKAY;
      s_rdata <= 32'h0000_0000;
      if (s_araddr == OFF_MODE)
        s_rdata <= {30'h0, protocol_mode_select_reg};
      else if (s_araddr == OFF_F1)
        s_rdata <= {11'h0, first_field_position_reg, first_field_mask_reg,
                    first_field_match_reg};
      else if (s_araddr == OFF_F2_MATCH_LO)
        s_rdata <= second_field_match_reg[31:0];
      else if (s_araddr == OFF_F2_MATCH_HI)
        s_rdata <= second_field_match_reg[63:32];
      else if (s_araddr == OFF_F2_MASK_LO)
        s_rdata <= second_field_mask_reg[31:0];
      else if (s_araddr == OFF_F2_MASK_HI)
        s_rdata <= second_field_mask_reg[63:32];
      else if (s_araddr == OFF_NEXT)
        s_rdata <= {1'b0, second_field_position_reg, 3'h0,
                    flow_field_position_reg, 5'h00,
                    next_stage_pointer_reg, header_length_bytes_reg};
      else if (s_araddr == OFF_UDP)
        s_rdata <= {16'h0, udp_sum_location_reg, 4'h0, udp_sum_length_reg,
                    udp_sum_fixup_enable_reg, udp_sum_zero_enable_reg};
      else if (s_araddr == OFF_FLOW_CTRL)
        s_rdata <= {29'h0, flow_address_select_reg, flow_enable_bit_reg};
      else if (s_araddr[7:4] == OFF_FLOW_MATCH0[7:4] && s_araddr[1:0] == 2'h0)
        s_rdata <= flow_match_value_reg[32*s_araddr[3:2] +: 32];
      else if (s_araddr[7:4] == OFF_FLOW_MASK0[7:4] && s_araddr[1:0] == 2'h0)
        s_rdata <= flow_match_mask_reg[32*s_araddr[3:2] +: 32];
      else if (s_araddr == OFF_STATUS)
        s_rdata <= {hit_count_reg, hdr_count_reg};
      else
        s_rresp <= RESP_SLVERR;
    end
    else if (s_rready)
      s_rvalid <= 1'b0;
  end

  // ---------------- header checks ----------------
  logic [3:0] version;
  logic ver_ok;
  logic frag_ok;
  logic [7:0] f1_byte;
  logic f1_ok;
  logic [63:0] f2_field;
  logic f2_ok;
  logic [127:0] src_field;
  logic [127:0] dst_field;
  logic [127:0] eff_mask;
  logic src_hit;
  logic dst_hit;
  logic flow_hit;

  // fetch eight bytes starting at a byte position, first byte highest
  function automatic logic [63:0] get8(input logic [8*HDR_BYTES-1:0] h,
                                       input logic [6:0] pos);
    logic [63:0] r;
    r = 64'h0;
    for (int i = 0; i < 8; i++)
      if (int'(pos) + i < HDR_BYTES)
        r[63-8*i -: 8] = h[8*(int'(pos)+i) +: 8];
    return r;
  endfunction

  // fetch sixteen bytes at a byte position, first byte highest
  function automatic logic [127:0] get16(input logic [8*HDR_BYTES-1:0] h,
                                         input logic [6:0] pos);
    return {get8(h, pos), get8(h, 7'(pos + 7'h08))};
  endfunction

  // mode-dependent version and fragment checks
  always_comb
  begin
    version = hdr_bytes[7:4];
    ver_ok = 1'b1;
    frag_ok = 1'b1;
    case (protocol_mode_select_reg)
      MODE_IPV4:
      begin
        ver_ok = (version == VER_V4);
        // flags/offset in bytes 6..7; mf is bit 5 of byte 6
        frag_ok = !hdr_bytes[8*6+5] && hdr_bytes[8*6 +: 5] == 5'h00 &&
                  hdr_bytes[8*7 +: 8] == 8'h00;
      end
      MODE_IPV6:
        ver_ok = (version == VER_V6);
      default:
        ver_ok = 1'b1;
    endcase
  end

  // match/mask pairs; an all-zero mask passes every header
  assign f1_byte = hdr_bytes[8*first_field_position_reg +: 8];
  assign f1_ok = ((f1_byte ^ first_field_match_reg) &
                  first_field_mask_reg) == 8'h00;
  assign f2_field = get8(hdr_bytes, second_field_position_reg);
  assign f2_ok = ((f2_field ^ second_field_match_reg) &
                  second_field_mask_reg) == 64'h0;

  // flow field: in ip modes the destination follows the source address
  always_comb
  begin
    src_field = get16(hdr_bytes, {2'h0, flow_field_position_reg});
    dst_field = 128'h0;
    eff_mask = flow_match_mask_reg;
    case (protocol_mode_select_reg)
      MODE_IPV4:
      begin
        // only the upper word takes part for a 32-bit address
        eff_mask = {flow_match_mask_reg[127:96], 96'h0};
        dst_field = get16(hdr_bytes,
                          7'({2'h0, flow_field_position_reg} + 7'h04));
      end
      MODE_IPV6:
        dst_field = get16(hdr_bytes,
                          7'({2'h0, flow_field_position_reg} + 7'h10));
      MODE_OTHER32:
        eff_mask = {flow_match_mask_reg[127:96], 96'h0};
      default:
        eff_mask = flow_match_mask_reg;
    endcase
  end

  assign src_hit = ((src_field ^ flow_match_value_reg) & eff_mask) == 128'h0;
  assign dst_hit = ((dst_field ^ flow_match_value_reg) & eff_mask) == 128'h0;

  // address select only applies in the ip modes
  always_comb
  begin
    flow_hit = src_hit;
    if (protocol_mode_select_reg == MODE_IPV4 ||
        protocol_mode_select_reg == MODE_IPV6)
    begin
      case (flow_address_select_reg)
        SEL_SRC: flow_hit = src_hit;
        SEL_DST: flow_hit = dst_hit;
        SEL_EITHER: flow_hit = src_hit || dst_hit;
        default: flow_hit = 1'b0; // reserved select never hits
      endcase
    end
  end

  // assemble the result; settings pass through to the next stage
  always_comb
  begin
    result_next = result_reg;
    result_next.valid = hdr_valid;
    if (hdr_valid)
    begin
      result_next.header_ok = ver_ok && frag_ok && f1_ok && f2_ok;
      result_next.flow_hit = result_next.header_ok && flow_hit &&
                             flow_enable_bit_reg;
      result_next.next_ptr = next_stage_pointer_reg;
      result_next.hdr_len = header_length_bytes_reg;
      // the two sum settings are passed as written; software keeps them apart
      result_next.sum_zero = udp_sum_zero_enable_reg;
      result_next.sum_fix = udp_sum_fixup_enable_reg;
      result_next.sum_loc = (protocol_mode_select_reg == MODE_IPV4) ?
                            udp_sum_location_reg : 8'h00;
      result_next.sum_len = udp_sum_length_reg;
    end
  end

  // result register, one cycle after the header is offered
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      result_reg <= '0;
    else
      result_reg <= result_next;
  end

  assign result = result_reg;

  // status counters, wrap at full scale
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      hdr_count_reg <= 16'h0000;
      hit_count_reg <= 16'h0000;
    end
    else if (hdr_valid)
    begin
      hdr_count_reg <= hdr_count_reg + 16'h0001;
      if (result_next.flow_hit)
        hit_count_reg <= hit_count_reg + 16'h0001;
    end
  end

endmodule

// >>> dv/hdr_cmp_sva.sv
`timescale 1ns/1ps
// watches the comparator ports; one clock domain only
module hdr_cmp_sva
  import hdr_cmp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // header path
  input wire logic hdr_valid,
  input wire logic [8*HDR_BYTES-1:0] hdr_bytes,
  input wire stage_result_t result,
  // register bus
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  input wire logic s_rready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // both write channels taken at one edge
  sequence s_wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  // read taken at an address past the map
  sequence s_rd_bad;
    s_arvalid && s_arready && s_araddr >= 8'h54;
  endsequence
  // an ipv4 header that passed (location is zero in other modes)
  sequence s_v4_ok;
    result.valid && result.header_ok && result.sum_loc != 8'h0;
  endsequence
  a_valid_delay: assert property (result.valid == $past(hdr_valid))
    else $error("result valid not one cycle after header");
  a_hit_needs_ok: assert property (
    result.valid && result.flow_hit |-> result.header_ok)
    else $error("flow hit without header ok");
  a_v4_version: assert property (
    s_v4_ok |-> $past(hdr_bytes[7:4]) == VER_V4)
    else $error("ipv4 passed with wrong version");
  a_v4_unfrag: assert property (
    s_v4_ok |-> $past(hdr_bytes[63:56]) == 8'h0
      && $past(hdr_bytes[53:48]) == 6'h0)
    else $error("ipv4 fragment passed");
  a_idle_hold: assert property (!result.valid |-> $stable(result[24:0]))
    else $error("result fields moved while idle");
  a_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_bvalid)
    else $error("write response late");
  a_rd_unmapped: assert property (s_rd_bad |=> s_rvalid
    && s_rresp == RESP_SLVERR && s_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_resp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid
    && $stable(s_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_rvalid && !s_rready |=> s_rvalid
    && $stable(s_rdata))
    else $error("read data dropped");
  a_busy_refuse: assert property (s_rvalid |-> !s_arready)
    else $error("read taken while answer pending");
endmodule

bind hdr_cmp hdr_cmp_sva i_sva (.mclk(mclk), .reset(reset),
  .hdr_valid(hdr_valid), .hdr_bytes(hdr_bytes), .result(result),
  .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid),
  .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
  .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
  .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
  .s_rvalid(s_rvalid), .s_rready(s_rready));

// >>> dv/hdr_src_model.sv
`timescale 1ns/1ps
// preceding stage: presents one header window per call
module hdr_src_model
  import hdr_cmp_pkg::*;
(
  // clock
  input wire logic mclk,
  // header window toward the comparator
  output logic hdr_valid,
  output logic [8*HDR_BYTES-1:0] hdr_bytes
);
  initial
  begin
    hdr_valid = 1'b0;
    hdr_bytes = '0;
  end
  // after the window the bytes turn inverse, so stale data never matches
  task automatic send(input logic [8*HDR_BYTES-1:0] b);
    @(posedge mclk);
    hdr_valid <= 1'b1;
    hdr_bytes <= b;
    @(posedge mclk);
    hdr_valid <= 1'b0;
    hdr_bytes <= ~b;
  endtask
endmodule

// >>> dv/hdr_cmp_tb.sv
`timescale 1ns/1ps
module hdr_cmp_tb
  import hdr_cmp_pkg::*;
();
  logic mclk, reset, hdr_valid, s_awvalid, s_awready, s_wvalid, s_wready;
  logic s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [8*HDR_BYTES-1:0] hdr_bytes, h;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, sa, da;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  stage_result_t result, e;
  stage_result_t exp_q[$];
  logic [33:0] rd_q[$];
  logic [1:0] wr_q[$];
  int n_fail, tests_run, cycles, seed_v;

  hdr_src_model i_src (.mclk(mclk), .hdr_valid(hdr_valid),
    .hdr_bytes(hdr_bytes));
  hdr_cmp i_dut (.mclk(mclk), .reset(reset), .hdr_valid(hdr_valid),
    .hdr_bytes(hdr_bytes), .result(result), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(input logic [33:0] w, input logic [33:0] g);
    tests_run++;
    if (g !== w)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, w);
    end
  endtask

  task automatic finish_test;
    check(34'h0, 34'(exp_q.size() + rd_q.size() + wr_q.size()));
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // monitor: pre-edge values, so registered outputs are settled
  always @(posedge mclk)
  begin
    if (!reset && result.valid)
      check(34'(exp_q.pop_front()), 34'(result));
    if (s_rvalid && s_rready)
      check(rd_q.pop_front(), {s_rresp, s_rdata});
    if (s_bvalid && s_bready)
      check(34'(wr_q.pop_front()), 34'(s_bresp));
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end

  // ready is sampled at the falling edge, stable up to the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    logic ta, tw;
    wr_q.push_back(r);
    @(posedge mclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do
    begin
      @(negedge mclk);
      ta = s_awvalid && s_awready;
      tw = s_wvalid && s_wready;
      @(posedge mclk);
      if (ta)
        s_awvalid <= 1'b0;
      if (tw)
        s_wvalid <= 1'b0;
    end while ((s_awvalid && !ta) || (s_wvalid && !tw));
    do @(negedge mclk); while (!s_bvalid);
    // late bready so the slave must hold its answer
    @(posedge mclk);
    s_bready <= 1'b1;
    @(posedge mclk);
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] w);
    rd_q.push_back(w);
    @(posedge mclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(negedge mclk); while (!s_arready);
    @(posedge mclk);
    s_arvalid <= 1'b0;
    do @(negedge mclk); while (!s_rvalid);
    @(posedge mclk);
    s_rready <= 1'b1;
    @(posedge mclk);
    s_rready <= 1'b0;
  endtask

  // random header with version, one tested byte and two addresses
  function automatic logic [511:0] mk(input logic [3:0] v, input int pp,
    input logic [7:0] p, input int ap, input logic [31:0] a, input int dp,
    input logic [31:0] d);
    logic [511:0] x;
    for (int i = 0; i < 16; i++)
      x[32*i+:32] = $urandom;
    x[7:4] = v;
    x[63:48] = 16'h0;
    x[8*pp+:8] = p;
    for (int i = 0; i < 4; i++)
    begin
      x[8*(ap+i)+:8] = a[31-8*i-:8];
      x[8*(dp+i)+:8] = d[31-8*i-:8];
    end
    return x;
  endfunction

  task automatic hdr(input logic [511:0] b, input logic ok, input logic hit);
    e.valid = 1'b1;
    e.header_ok = ok;
    e.flow_hit = hit;
    exp_q.push_back(e);
    i_src.send(b);
  endtask

  initial
  begin
    reset = 1'b1;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = {48'h0, 4'hf};
    seed_v = $urandom(65);
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rd(OFF_MODE, 34'h0);
    rd(OFF_UDP, {RESP_OKAY, 32'h8});
    rd(8'h60, {RESP_SLVERR, 32'h0});
    wr(8'h60, 32'h1, RESP_SLVERR);
    wr(OFF_STATUS, 32'h1, RESP_SLVERR);
    sa = $urandom;
    da = ~sa;
    // ipv4: protocol byte 9, flow at source address
    wr(OFF_F1, 32'h0009ff11, RESP_OKAY);
    wr(OFF_NEXT, 32'h000c051c, RESP_OKAY);
    wr(OFF_UDP, 32'h00001a09, RESP_OKAY);
    wr(OFF_FLOW_CTRL, 32'h1, RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_FLOW_MATCH0 + 8'(4*i), (i == 3) ? sa : $urandom, RESP_OKAY);
      wr(OFF_FLOW_MASK0 + 8'(4*i), 32'hffffffff, RESP_OKAY);
    end
    rd(OFF_NEXT, {RESP_OKAY, 32'h000c051c});
    e = '0;
    e.next_ptr = 3'h5;
    e.hdr_len = 8'h1c;
    e.sum_zero = 1'b1;
    e.sum_loc = 8'h1a;
    e.sum_len = 2'h2;
    h = mk(VER_V4, 9, 8'h11, 12, sa, 16, da);
    hdr(h, 1'b1, 1'b1);
    hdr({h[511:8], h[7:4] ^ 4'h1, h[3:0]}, 1'b0, 1'b0);
    hdr(h | (512'h1 << 53), 1'b0, 1'b0);
    hdr(h | (512'h1 << 56), 1'b0, 1'b0);
    hdr(mk(VER_V4, 9, 8'h06, 12, sa, 16, da), 1'b0, 1'b0);
    for (int s = 0; s < 3; s++)
    begin
      wr(OFF_FLOW_CTRL, 32'(2*s+1), RESP_OKAY);
      hdr(mk(VER_V4, 9, 8'h11, 12, da, 16, sa), 1'b1, s != 0);
      hdr(mk(VER_V4, 9, 8'h11, 12, sa, 16, da), 1'b1, s != 1);
    end
    wr(OFF_FLOW_CTRL, 32'h0, RESP_OKAY);
    hdr(h, 1'b1, 1'b0);
    // second pair over both addresses, then first pair disabled
    wr(OFF_FLOW_CTRL, 32'h1, RESP_OKAY);
    wr(OFF_F2_MATCH_LO, da, RESP_OKAY);
    wr(OFF_F2_MATCH_HI, sa, RESP_OKAY);
    wr(OFF_F2_MASK_LO, 32'hffffffff, RESP_OKAY);
    wr(OFF_F2_MASK_HI, 32'hffffffff, RESP_OKAY);
    wr(OFF_NEXT, 32'h0c0c051c, RESP_OKAY);
    s_wstrb <= 4'h1;
    wr(OFF_NEXT, 32'hffffff1c, RESP_OKAY);
    s_wstrb <= 4'hf;
    hdr(h, 1'b1, 1'b1);
    hdr(mk(VER_V4, 9, 8'h11, 12, sa, 16, sa), 1'b0, 1'b0);
    wr(OFF_F1, 32'h00090011, RESP_OKAY);
    hdr(mk(VER_V4, 9, 8'h06, 12, sa, 16, da), 1'b1, 1'b1);
    // ipv6: next header byte 6, upper flow word only
    wr(OFF_MODE, 32'h1, RESP_OKAY);
    wr(OFF_F1, 32'h0006ff11, RESP_OKAY);
    wr(OFF_NEXT, 32'h00080128, RESP_OKAY);
    wr(OFF_UDP, 32'h00001a0a, RESP_OKAY);
    wr(OFF_F2_MASK_LO, 32'h0, RESP_OKAY);
    wr(OFF_F2_MASK_HI, 32'h0, RESP_OKAY);
    for (int i = 0; i < 3; i++)
      wr(OFF_FLOW_MASK0 + 8'(4*i), 32'h0, RESP_OKAY);
    e.next_ptr = 3'h1;
    e.hdr_len = 8'h28;
    e.sum_zero = 1'b0;
    e.sum_fix = 1'b1;
    e.sum_loc = 8'h0;
    hdr(mk(VER_V6, 6, 8'h11, 8, sa, 24, da), 1'b1, 1'b1);
    hdr(mk(VER_V4, 6, 8'h11, 8, sa, 24, da), 1'b0, 1'b0);
    // other modes: no version check, masked flow field
    wr(OFF_F1, 32'h0, RESP_OKAY);
    for (int m = 2; m < 4; m++)
    begin
      wr(OFF_MODE, 32'(m), RESP_OKAY);
      wr(OFF_NEXT, 32'h00080010 | 32'(m << 8), RESP_OKAY);
      e.next_ptr = 3'(m);
      e.hdr_len = 8'h10;
      hdr(mk(4'h9, 6, 8'h0, 8, sa, 24, da), 1'b1, 1'b1);
      hdr(mk(4'h9, 6, 8'h0, 8, da, 24, sa), 1'b1, 1'b0);
    end
    rd(OFF_STATUS, {RESP_OKAY, 32'h000a0015});
    repeat (3) @(posedge mclk);
    finish_test();
  end
endmodule
